// *** common/sdbs_defs.svh ***
// Constants shared by both ends of the burst memory link.
`ifndef SDBS_DEFS_SVH
`define SDBS_DEFS_SVH
`define SDBS_AW 21
`define SDBS_DW 36
`define SDBS_BYTES 4
`define SDBS_BYTE_W 9
`define SDBS_MEM_AW 4
`define SDBS_MCLK_NS 40
`define SDBS_LINK_NS 320
`define SDBS_HALF ((`SDBS_LINK_NS / 2) / `SDBS_MCLK_NS)
`define SDBS_CNT_W 3
`define SDBS_CNT_RST 3'h4
`define SDBS_PT_ADDR 3'h6
`define SDBS_PT_BEAT1 3'h2
`define SDBS_LAT_LOOP 2'h2
`define SDBS_LAT_BYP 2'h1
`define SDBS_FIFO_DEPTH 4
`endif

// *** common/sdbs_if.sv ***
// Link between the memory controller end and the burst memory end.
`timescale 1ns/1ps
`default_nettype none
`include "sdbs_defs.svh"
interface sdbs_if;
  logic k;
  logic k_n;
  logic [`SDBS_AW-1:0] addr;
  logic rd_sel_n;
  logic wr_sel_n;
  logic [`SDBS_DW-1:0] d;
  logic [`SDBS_BYTES-1:0] byte_write_select_n;
  logic loop_bypass_select;
  logic [`SDBS_DW-1:0] q;
  logic echo_clock;
  logic echo_clock_n;
  logic read_valid_flag;

  modport dev (
    input k, k_n, addr, rd_sel_n, wr_sel_n, d, byte_write_select_n, loop_bypass_select,
    output q, echo_clock, echo_clock_n, read_valid_flag
  );
  modport host (
    output k, k_n, addr, rd_sel_n, wr_sel_n, d, byte_write_select_n, loop_bypass_select,
    input q, echo_clock, echo_clock_n, read_valid_flag
  );
endinterface : sdbs_if
`default_nettype wire

// *** common/sdbs_pkg.sv ***
// Types shared by both ends of the burst memory link.
`include "sdbs_defs.svh"
package sdbs_pkg;
  typedef struct packed {
    logic we;
    logic [`SDBS_AW-1:0] addr;
    logic [2*`SDBS_DW-1:0] wdata;
    logic [2*`SDBS_BYTES-1:0] wmask_n;
  } sdbs_req_t;

  typedef struct packed {
    logic [`SDBS_AW-1:0] addr;
    logic rsel_n;
    logic wsel_n;
    logic [`SDBS_DW-1:0] d;
    logic [`SDBS_BYTES-1:0] bws_n;
    logic lbs;
  } sdbs_lnk_in_t;

  typedef struct packed {
    sdbs_lnk_in_t in_m;
    sdbs_lnk_in_t in_s;
    logic k_m;
    logic k_s;
    logic k_d;
    logic kn_m;
    logic kn_s;
    logic kn_d;
    logic phase;
    logic [(1<<`SDBS_MEM_AW)-1:0][2*`SDBS_DW-1:0] mem;
    logic wp_vld;
    logic wbeat;
    logic [`SDBS_MEM_AW-1:0] wp_addr;
    logic [2*`SDBS_DW-1:0] wp_data;
    logic [2*`SDBS_BYTES-1:0] wp_mask;
    logic [2*`SDBS_DW-1:0] rbuf;
    logic [1:0] rcnt;
    logic [`SDBS_DW-1:0] q;
    logic [`SDBS_DW-1:0] qhi;
    logic beat1_due;
    logic vld;
    logic echo;
    logic echo_n;
  } sdbs_dev_st_t;

  typedef struct packed {
    logic [`SDBS_CNT_W-1:0] cnt;
    logic k;
    logic slot;
    logic lbs;
    logic [`SDBS_AW-1:0] addr;
    logic rsel_n;
    logic wsel_n;
    logic [`SDBS_DW-1:0] d;
    logic [`SDBS_BYTES-1:0] bws_n;
    logic [`SDBS_DW-1:0] d_hi;
    logic [`SDBS_BYTES-1:0] bws_hi;
    logic ec_m;
    logic ec_s;
    logic ec_d;
    logic ecn_m;
    logic ecn_s;
    logic ecn_d;
    logic v_m;
    logic v_s;
    logic [`SDBS_DW-1:0] q_m;
    logic [`SDBS_DW-1:0] q_s;
    logic [`SDBS_DW-1:0] rd_lo;
    logic [2*`SDBS_DW-1:0] rsp_data;
    logic rsp_valid;
  } sdbs_host_st_t;
endpackage : sdbs_pkg

// *** rtl/sdbs_device.sv ***
// Burst memory end: separate read and write ports on one address bus.
`timescale 1ns/1ps
`default_nettype none
`include "sdbs_defs.svh"
module sdbs_device (
  // Clock and reset.
  input wire logic mclk,
  input wire logic srst,
  // Link to the memory controller.
  sdbs_if.dev lnk,
  // Observation of the pending write and the selected read latency.
  output logic write_pending,
  output logic [1:0] read_latency
);
  sdbs_pkg::sdbs_dev_st_t r;
  sdbs_pkg::sdbs_dev_st_t n;
  sdbs_pkg::sdbs_lnk_in_t pins;
  logic k_rise;
  logic kn_rise;
  logic [1:0] lat;
  logic [`SDBS_MEM_AW-1:0] a_idx;

  // Byte-lane merge used both for forwarding and for the array write.
  function automatic logic [2*`SDBS_DW-1:0] sdbs_merge(
    input logic [2*`SDBS_DW-1:0] old_w,
    input logic [2*`SDBS_DW-1:0] new_w,
    input logic [2*`SDBS_BYTES-1:0] en
  );
    logic [2*`SDBS_DW-1:0] res;
    res = old_w;
    for (int i = 0; i < 2*`SDBS_BYTES; i++) begin
      if (en[i]) begin
        res[i*`SDBS_BYTE_W +: `SDBS_BYTE_W] = new_w[i*`SDBS_BYTE_W +: `SDBS_BYTE_W];
      end
    end
    return res;
  endfunction : sdbs_merge

  // Gather the link inputs into one bundle for the input register.
  always_comb begin
    pins.addr = lnk.addr;
    pins.rsel_n = lnk.rd_sel_n;
    pins.wsel_n = lnk.wr_sel_n;
    pins.d = lnk.d;
    pins.bws_n = lnk.byte_write_select_n;
    pins.lbs = lnk.loop_bypass_select;
  end

  // Edges are found only on the second sync stage, never on the first.
  assign k_rise = r.k_s & ~r.k_d;
  assign kn_rise = r.kn_s & ~r.kn_d;
  assign lat = r.in_s.lbs ? `SDBS_LAT_LOOP : `SDBS_LAT_BYP;
  assign a_idx = r.in_s.addr[`SDBS_MEM_AW-1:0];

  // Read data, flag and echo clocks all leave from the state register.
  assign lnk.q = r.q;
  assign lnk.read_valid_flag = r.vld;
  assign lnk.echo_clock = r.echo;
  assign lnk.echo_clock_n = r.echo_n;
  assign write_pending = r.wp_vld;
  assign read_latency = lat;

  // Next-state logic for the whole device.
  always_comb begin
    n = r;
    // Every link input, clocks included, passes two flops before use.
    n.in_m = pins;
    n.in_s = r.in_m;
    n.k_m = lnk.k;
    n.k_s = r.k_m;
    n.k_d = r.k_s;
    n.kn_m = lnk.k_n;
    n.kn_s = r.kn_m;
    n.kn_d = r.kn_s;
    // The echo clocks follow the sampled clocks in the same cycle as the data moves.
    n.echo = r.k_s;
    n.echo_n = r.kn_s;

    if (k_rise) begin
      // A burst that has been shown in full is withdrawn at the next true rise.
      n.vld = 1'b0;
      // Launch happens before a new load, so back-to-back reads cannot collide.
      if (r.rcnt == 2'h1) begin
        n.q = r.rbuf[`SDBS_DW-1:0];
        n.qhi = r.rbuf[2*`SDBS_DW-1:`SDBS_DW];
        n.vld = 1'b1;
        n.beat1_due = 1'b1;
      end
      if (r.rcnt != 2'h0) begin
        n.rcnt = r.rcnt - 2'h1;
      end
      // Address phases alternate: read slot, then write slot.
      n.phase = ~r.phase;
      if (!r.phase) begin
        // Read slot; a pending write to the same word is forwarded byte by byte.
        if (!r.in_s.rsel_n) begin
          if (r.wp_vld && (r.wp_addr == a_idx)) begin
            n.rbuf = sdbs_merge(r.mem[a_idx], r.wp_data, r.wp_mask);
          end else begin
            n.rbuf = r.mem[a_idx];
          end
          n.rcnt = lat;
        end
      end else begin
        // Write slot; the previous write retires into the array on its own.
        if (r.wp_vld) begin
          n.mem[r.wp_addr] = sdbs_merge(r.mem[r.wp_addr], r.wp_data, r.wp_mask);
          n.wp_vld = 1'b0;
        end
        if (!r.in_s.wsel_n) begin
          n.wp_addr = a_idx;
          n.wp_data[`SDBS_DW-1:0] = r.in_s.d;
          n.wp_mask[`SDBS_BYTES-1:0] = ~r.in_s.bws_n;
          n.wbeat = 1'b1;
        end
      end
    end

    if (kn_rise) begin
      // Second beat of each burst moves on the complementary clock rise.
      if (r.beat1_due) begin
        n.q = r.qhi;
        n.beat1_due = 1'b0;
      end
      if (r.wbeat) begin
        n.wp_data[2*`SDBS_DW-1:`SDBS_DW] = r.in_s.d;
        n.wp_mask[2*`SDBS_BYTES-1:`SDBS_BYTES] = ~r.in_s.bws_n;
        n.wp_vld = 1'b1;
        n.wbeat = 1'b0;
      end
    end
  end

  // State register; the array itself is not cleared by reset in a real part,
  // but clearing it here keeps reads of unwritten words defined.
  // The complementary clock idles high in reset, so its sync stages and echo start high
  // as well; starting them low would show a false rise just after reset.
  always_ff @(posedge mclk) begin
    if (srst) begin
      r <= '0;
      r.kn_m <= 1'b1;
      r.kn_s <= 1'b1;
      r.kn_d <= 1'b1;
      r.echo_n <= 1'b1;
    end else begin
      r <= n;
    end
  end
endmodule : sdbs_device
`default_nettype wire

// *** rtl/sdbs_fifo.sv ***
// Small request FIFO with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none
module sdbs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic srst,
  // Filling side.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side.
  input wire logic out_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } sdbs_fifo_st_t;

  sdbs_fifo_st_t r;
  sdbs_fifo_st_t n;
  logic push;
  logic pop;

  // Full and empty come straight from the occupancy count.
  assign in_ready = (r.cnt != (AW+1)'(DEPTH));
  assign out_valid = (r.cnt != '0);
  assign out_data = r.mem[r.rp];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Pointers wrap naturally, so the depth must be a power of two.
  always_comb begin
    n = r;
    if (push) begin
      n.mem[r.wp] = in_data;
      n.wp = r.wp + 1'b1;
    end
    if (pop) begin
      n.rp = r.rp + 1'b1;
    end
    n.cnt = r.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  // State register.
  always_ff @(posedge mclk) begin
    if (srst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end
endmodule : sdbs_fifo
`default_nettype wire

// *** rtl/sdbs_host.sv ***
// Memory controller end: makes the link clock, issues bursts, collects reads.
`timescale 1ns/1ps
`default_nettype none
`include "sdbs_defs.svh"
module sdbs_host (
  // Clock and reset.
  input wire logic mclk,
  input wire logic srst,
  // Mode selection passed to the memory.
  input wire logic mode_loop,
  // Request port.
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [`SDBS_AW-1:0] req_addr,
  input wire logic [2*`SDBS_DW-1:0] req_wdata,
  input wire logic [2*`SDBS_BYTES-1:0] req_wmask_n,
  // Read answer port.
  output logic rsp_valid,
  output logic [2*`SDBS_DW-1:0] rsp_data,
  // Link to the memory.
  sdbs_if.host lnk
);
  sdbs_pkg::sdbs_host_st_t r;
  sdbs_pkg::sdbs_host_st_t n;
  sdbs_pkg::sdbs_req_t in_req;
  sdbs_pkg::sdbs_req_t head;
  logic head_valid;
  logic head_ready;
  logic e_rise;
  logic en_rise;

  assign in_req = '{we: req_write, addr: req_addr, wdata: req_wdata, wmask_n: req_wmask_n};

  // Queue absorbs requests while the link waits for the matching slot.
  sdbs_fifo #(
    .WIDTH($bits(sdbs_pkg::sdbs_req_t)),
    .DEPTH(`SDBS_FIFO_DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .srst(srst),
    .in_valid(req_valid),
    .in_ready(req_ready),
    .in_data(in_req),
    .out_ready(head_ready),
    .out_valid(head_valid),
    .out_data(head)
  );

  // The head leaves only at setup time of a slot of its own kind.
  assign head_ready = (r.cnt == `SDBS_PT_ADDR) && (head.we == r.slot);
  assign e_rise = r.ec_s & ~r.ec_d;
  assign en_rise = r.ecn_s & ~r.ecn_d;

  // Link outputs come from the state register.
  assign lnk.k = r.k;
  assign lnk.k_n = ~r.k;
  assign lnk.addr = r.addr;
  assign lnk.rd_sel_n = r.rsel_n;
  assign lnk.wr_sel_n = r.wsel_n;
  assign lnk.d = r.d;
  assign lnk.byte_write_select_n = r.bws_n;
  assign lnk.loop_bypass_select = r.lbs;
  assign rsp_valid = r.rsp_valid;
  assign rsp_data = r.rsp_data;

  // Divider, issue sequencer and read capture.
  always_comb begin
    n = r;
    n.cnt = r.cnt + 1'b1;
    n.k = (n.cnt < `SDBS_CNT_W'(`SDBS_HALF));
    n.lbs = mode_loop;
    n.rsp_valid = 1'b0;
    // Outputs change one mclk before each link clock edge so they are steady around each clock rise.
    if (r.cnt == `SDBS_PT_ADDR) begin
      n.rsel_n = 1'b1;
      n.wsel_n = 1'b1;
      if (head_valid && head_ready) begin
        n.addr = head.addr;
        if (head.we) begin
          n.wsel_n = 1'b0;
          n.d = head.wdata[`SDBS_DW-1:0];
          n.bws_n = head.wmask_n[`SDBS_BYTES-1:0];
          n.d_hi = head.wdata[2*`SDBS_DW-1:`SDBS_DW];
          n.bws_hi = head.wmask_n[2*`SDBS_BYTES-1:`SDBS_BYTES];
        end else begin
          n.rsel_n = 1'b0;
        end
      end
    end
    if (r.cnt == `SDBS_PT_BEAT1) begin
      n.d = r.d_hi;
      n.bws_n = r.bws_hi;
      n.rsel_n = 1'b1;
      n.wsel_n = 1'b1;
      n.slot = ~r.slot;
    end
    // Returned signals pass two flops; the first stage feeds only the second.
    n.ec_m = lnk.echo_clock;
    n.ec_s = r.ec_m;
    n.ec_d = r.ec_s;
    n.ecn_m = lnk.echo_clock_n;
    n.ecn_s = r.ecn_m;
    n.ecn_d = r.ecn_s;
    n.v_m = lnk.read_valid_flag;
    n.v_s = r.v_m;
    n.q_m = lnk.q;
    n.q_s = r.q_m;
    if (e_rise && r.v_s) begin
      n.rd_lo = r.q_s;
    end
    if (en_rise && r.v_s) begin
      n.rsp_data = {r.q_s, r.rd_lo};
      n.rsp_valid = 1'b1;
    end
  end

  // State register; the divider starts in the low half so no early rise occurs.
  always_ff @(posedge mclk) begin
    if (srst) begin
      r <= '0;
      r.cnt <= `SDBS_CNT_RST;
      r.rsel_n <= 1'b1;
      r.wsel_n <= 1'b1;
      r.bws_n <= '1;
      r.bws_hi <= '1;
      // The complementary echo idles high, so no false rise is seen after reset.
      r.ecn_m <= 1'b1;
      r.ecn_s <= 1'b1;
      r.ecn_d <= 1'b1;
    end else begin
      r <= n;
    end
  end
endmodule : sdbs_host
`default_nettype wire

// *** test/sdbs_link_checker.sv ***
// Concurrent checks on the link between the controller end and the memory end.
`timescale 1ns/1ps
`default_nettype none
`include "sdbs_defs.svh"
module sdbs_link_checker (
  // Clock and reset.
  input wire logic mclk,
  input wire logic srst,
  // Signals driven by the controller end.
  input wire logic k,
  input wire logic k_n,
  input wire logic rd_sel_n,
  input wire logic wr_sel_n,
  input wire logic loop_bypass_select,
  // Signals driven by the memory end.
  input wire logic [`SDBS_DW-1:0] q,
  input wire logic echo_clock,
  input wire logic echo_clock_n,
  input wire logic read_valid_flag
);
  // Everything here lives in the mclk domain, so clock and reset are given once.
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);

  // One link clock period is four mclk high and four low.
  sequence k_period_s;
    k [*4] ##1 !k [*4];
  endsequence
  // A burst launches beat0 with the true echo and beat1 half a period later.
  sequence burst_s;
    $rose(echo_clock) ##4 $rose(echo_clock_n);
  endsequence

  a_k_pair: assert property (k_n == !k)
    else $error("link clock pair not complementary");
  a_k_period: assert property ($rose(k) |-> k_period_s)
    else $error("link clock period wrong");
  a_sel_excl: assert property (rd_sel_n || wr_sel_n)
    else $error("read and write selected in one slot");
  a_rd_slot: assert property ($fell(rd_sel_n) |-> ##[1:3] $rose(k))
    else $error("read select not ahead of link clock rise");
  a_wr_hold: assert property ($fell(wr_sel_n) |-> !wr_sel_n [*4] ##1 wr_sel_n)
    else $error("write select not held for one slot");
  a_echo_burst: assert property ($rose(read_valid_flag) |-> burst_s)
    else $error("echo clocks not aligned with burst");
  // Echo clocks run free, so the flag is tied to them only where it rises or falls.
  a_echo_valid: assert property ($fell(read_valid_flag) |-> $rose(echo_clock))
    else $error("valid flag not withdrawn at true echo rise");
  a_valid_hold: assert property ($rose(read_valid_flag) |-> read_valid_flag [*8])
    else $error("valid flag dropped inside burst");
  a_q_launch: assert property ($changed(q) && read_valid_flag
      |-> $rose(echo_clock) || $rose(echo_clock_n))
    else $error("read data moved without echo edge");
  a_lat_loop: assert property (loop_bypass_select && $fell(rd_sel_n)
      |-> ##[17:24] $rose(read_valid_flag))
    else $error("read latency wrong with loop on");
  a_lat_byp: assert property (!loop_bypass_select && $fell(rd_sel_n)
      |-> ##[9:16] $rose(read_valid_flag))
    else $error("read latency wrong with loop bypassed");
endmodule : sdbs_link_checker
`default_nettype wire

// *** test/separate_port_ddr_burst_sram_test.sv ***
// Self-checking bench joining the controller end and the memory end.
`timescale 1ns/1ps
`default_nettype none
`include "sdbs_defs.svh"
module separate_port_ddr_burst_sram_test;
  // Stimulus, observation and reference model.
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic mode_loop = 1'b1;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic [`SDBS_AW-1:0] req_addr = '0;
  logic [2*`SDBS_DW-1:0] req_wdata = '0;
  logic [2*`SDBS_BYTES-1:0] req_wmask_n = '1;
  logic req_ready, rsp_valid, write_pending, full_seen;
  logic [2*`SDBS_DW-1:0] rsp_data;
  logic [1:0] read_latency;
  logic [2*`SDBS_DW-1:0] mem_m [16];
  logic [2*`SDBS_DW-1:0] exp_q [$];
  int miscompares = 0;
  int checked = 0;
  int cycles = 0;
  int seed = 34921;

  sdbs_if sdbs_if_inst ();
  sdbs_host sdbs_host_inst (.mclk(mclk), .srst(srst), .mode_loop(mode_loop),
    .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
    .req_addr(req_addr), .req_wdata(req_wdata), .req_wmask_n(req_wmask_n),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .lnk(sdbs_if_inst.host));
  sdbs_device sdbs_device_inst (.mclk(mclk), .srst(srst), .lnk(sdbs_if_inst.dev),
    .write_pending(write_pending), .read_latency(read_latency));
  sdbs_link_checker sdbs_link_checker_inst (.mclk(mclk), .srst(srst),
    .k(sdbs_if_inst.k), .k_n(sdbs_if_inst.k_n), .rd_sel_n(sdbs_if_inst.rd_sel_n),
    .wr_sel_n(sdbs_if_inst.wr_sel_n), .loop_bypass_select(sdbs_if_inst.loop_bypass_select),
    .q(sdbs_if_inst.q), .echo_clock(sdbs_if_inst.echo_clock),
    .echo_clock_n(sdbs_if_inst.echo_clock_n), .read_valid_flag(sdbs_if_inst.read_valid_flag));

  // Free-running system clock.
  always #(`SDBS_MCLK_NS / 2) mclk = ~mclk;

  task automatic test_done();
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : test_done

  task automatic check(input logic [2*`SDBS_DW-1:0] want, input logic [2*`SDBS_DW-1:0] got);
    checked++;
    if (got !== want) begin
      miscompares++;
      $display("[FAIL] t=%0t want=%h got=%h", $time, want, got);
    end
  endtask : check

  // One request held until taken; the model is updated at the taking edge.
  task automatic send(input logic we, input logic [`SDBS_AW-1:0] a,
      input logic [2*`SDBS_DW-1:0] wd, input logic [2*`SDBS_BYTES-1:0] m);
    @(negedge mclk);
    req_valid = 1'b1;
    req_write = we;
    req_addr = a;
    req_wdata = wd;
    req_wmask_n = m;
    while (req_ready !== 1'b1) begin
      full_seen = 1'b1;
      @(negedge mclk);
    end
    @(posedge mclk);
    if (we) begin
      for (int i = 0; i < 2*`SDBS_BYTES; i++) begin
        if (!m[i]) begin
          mem_m[a[3:0]][`SDBS_BYTE_W*i +: `SDBS_BYTE_W] = wd[`SDBS_BYTE_W*i +: `SDBS_BYTE_W];
        end
      end
    end else begin
      exp_q.push_back(mem_m[a[3:0]]);
    end
  endtask : send

  // Answers are compared in order; the cycle count cuts a hang short.
  always @(negedge mclk) begin
    cycles++;
    if (cycles > 20000) begin
      miscompares++;
      test_done();
    end
    if (rsp_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        miscompares++;
        $display("[FAIL] t=%0t want=%h got=%h", $time, 72'h0, rsp_data);
      end else begin
        check(exp_q.pop_front(), rsp_data);
      end
    end
  end

  // Both latency modes, each after its own reset, with burst traffic.
  initial begin
    logic [95:0] r;
    for (int p = 0; p < 2; p++) begin
      @(negedge mclk);
      srst = 1'b1;
      mode_loop = (p == 0);
      full_seen = 1'b0;
      repeat (20) @(negedge mclk);
      srst = 1'b0;
      foreach (mem_m[i]) mem_m[i] = '0;
      repeat (12) @(negedge mclk);
      check(mode_loop ? `SDBS_LAT_LOOP : `SDBS_LAT_BYP, read_latency);
      send(1'b0, 21'h00005, '0, '1);
      for (int n = 0; n < 24; n++) begin
        r = {$random(seed), $random(seed), $random(seed)};
        send(1'b1, r[84:64], r[71:0], r[79:72]);
        send(1'b0, r[84:64], '0, '1);
        if (n[0]) send(1'b0, r[95:75], '0, '1);
      end
      @(negedge mclk);
      req_valid = 1'b0;
      check(1'b1, full_seen);
      for (int w = 0; w < 3000 && exp_q.size() != 0; w++) @(negedge mclk);
      check(0, exp_q.size());
      repeat (40) @(negedge mclk);
      check(1'b0, write_pending);
    end
    test_done();
  end
endmodule : separate_port_ddr_burst_sram_test
`default_nettype wire
